// File: verilog/monitor_map.svh
// Register offsets, field positions, reset values and bus codes of the cycle monitor
`ifndef MONITOR_MAP_SVH
`define MONITOR_MAP_SVH

// ==========================================================
// Register map (byte addresses)
`define OFF_CTRL        4'h0
`define OFF_STATUS      4'h4
`define OFF_IRQ         4'h8
`define OFF_CYCLES      4'hC

// ==========================================================
// Control register
`define CTRL_LA_EN      0
`define CTRL_FLUSH_EXEC 1
`define CTRL_RESET      2'h1

// ==========================================================
// Status register fields
`define STAT_STATE_LSB  0
`define STAT_MODE_MIN   3
`define STAT_BANK_EN    4
`define STAT_IO_M_POL   5
`define STAT_LEVEL_LSB  6
`define STAT_LAST_F     10
`define STAT_SECOND_F   11

// ==========================================================
// Interrupt capture register
`define IRQ_MASKABLE    0
`define IRQ_NONMASK     1
`define IRQ_RESET       2'h0

// ==========================================================
// Processor status codes (status lines, active low as seen)
`define CODE_INTERRUPT_ACK_CYCLE       3'h0
`define CODE_IO_WR      3'h2
`define CODE_CODE       3'h4
`define CODE_MEM_WR     3'h6
`define CODE_PASSIVE    3'h7

// ==========================================================
// Queue status codes
`define QS_NONE         2'h0
`define QS_FIRST        2'h1
`define QS_FLUSH        2'h2
`define QS_NEXT         2'h3
`define QUEUE_MAX       4'hF

`endif

// File: verilog/monitor_pkg.sv
// Types shared by the cycle monitor modules
package monitor_pkg;

  // ==========================================================
  // Bus cycle tracker states
  typedef enum logic [2:0] {
    idle_state = 3'b000,
    t1_state   = 3'b001,
    t2_state   = 3'b010,
    t3_state   = 3'b011,
    wait_state = 3'b100,
    t4_state   = 3'b101
  } bus_state_t;

  // ==========================================================
  // Maximum-mode outputs of the processor
  typedef struct packed {
    logic [2:0] cpu_status_n;   // {cpu_status_bit2, cpu_status_bit1, cpu_status_bit0}
    logic [1:0] queue_status;
    logic       lock_n;
    logic       rq_gt0_n;
    logic       rq_gt1_n;
  } cpu_max_t;

  // Minimum-mode counterparts, in pin order
  typedef struct packed {
    logic mem_io;
    logic transfer_direction;
    logic data_enable_n;
    logic interrupt_ack_cycle_n;
    logic ale;
    logic write_n;
    logic hold_request;
    logic hold_acknowledge;
  } min_ctrl_t;

  // Control word handed to the analyzer
  typedef struct packed {
    logic rd_wr;
    logic mem_io;
    logic code_fetch;
    logic irq;
    logic min_mode;
    logic hold_ack;
    logic in_t1;
    logic in_wait;
    logic last_byte_first_flag;
    logic second_last_first_flag;
  } la_ctrl_t;

endpackage : monitor_pkg

// File: verilog/addr_latch.sv
// Transparent address latch for the 20-bit address and upper byte enable
`timescale 1ns/10ps
`include "monitor_map.svh"

module addr_latch (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        strobe_i,
  input  wire logic [20:0] bus_i,
  output logic      [20:0] latched_o
);

  typedef struct packed {
    logic [20:0] held;
  } latch_state_t;

  latch_state_t s_q;
  latch_state_t s_d;

  // ==========================================================
  // Follow while the strobe is high, keep the last value while low
  always_comb begin
    s_d = s_q;
    if (strobe_i) begin
      s_d.held = bus_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign latched_o = strobe_i ? bus_i : s_q.held;

endmodule : addr_latch

// File: verilog/queue_follower.sv
// Follows the processor instruction queue level and first-byte flags
`timescale 1ns/10ps
`include "monitor_map.svh"

module queue_follower (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] queue_status_i,
  input  wire logic [1:0] fill_bytes_i,
  input  wire logic       flush_exec_i,
  output logic      [3:0] level_o,
  output logic            last_first_o,
  output logic            second_last_first_o
);

  typedef struct packed {
    logic [3:0] level;
    logic       last_first;
    logic       second_first;
  } queue_state_t;

  queue_state_t s_q;
  queue_state_t s_d;
  logic   [4:0] sum;

  // ==========================================================
  // Level bookkeeping and first-byte history
  always_comb begin
    s_d = s_q;
    sum = {1'b0, s_q.level} + {3'h0, fill_bytes_i};
    unique case (queue_status_i)
      `QS_FIRST, `QS_NEXT: begin
        s_d.second_first = s_q.last_first;
        s_d.last_first   = (queue_status_i == `QS_FIRST);
        if (sum != 5'h00) begin
          sum = sum - 5'h01;
        end
      end
      `QS_FLUSH: begin
        // Flushed bytes either count as executed tail bytes or vanish
        sum = 5'h00;
        if (flush_exec_i) begin  // see R19
          s_d.second_first = s_q.last_first;
          s_d.last_first   = 1'b0;
        end else begin
          s_d.second_first = 1'b0;
          s_d.last_first   = 1'b0;
        end
      end
      `QS_NONE: begin
      end
    endcase
    s_d.level = (sum > {1'b0, `QUEUE_MAX}) ? `QUEUE_MAX : sum[3:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o             = s_q.level;
  assign last_first_o        = s_q.last_first;
  assign second_last_first_o = s_q.second_first;

endmodule : queue_follower

// File: verilog/cpu_bus_cycle_monitor.sv
// Bus cycle monitor: cycle tracker, strobe decode, mode emulation and analyzer feed
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`include "monitor_map.svh"

// Functional notes
// [R1] Every bus cycle runs at least four states
// [R2] Wait state sits between third and fourth
// [R3] No bus activity keeps the tracker idle
// [R4] Status change from passive generates latch strobe
// [R5] Latch strobe starts the first state
// [R6] Processor drives address in first state
// [R7] Read cycle floats address lines in second
// [R8] Write cycle drives data from second to fourth
// [R9] Address 20 bits, data 16 or 8
// [R10] Even bytes low lane, odd bytes high
// [R11] A0 and upper enable pick the banks
// [R12] Strap enables upper byte enable for wide
// [R13] Wide variant: select high means memory
// [R14] Narrow variant inverts select; strap picks polarity
// [R15] Target picks mode; processor stays maximum
// [R16] Minimum mode emulates and drives control signals
// [R17] Maximum mode forwards processor control outputs
// [R18] Queue level plus two first-byte flags
// [R19] Flushed queue bytes treated executed or discarded
// [R20] Trigger data from bus conditions, real time
// [R21] Only maskable and non-maskable requests captured
// [R22] Maskable request gives two acknowledge cycles
// [R23] Address latch transparent high, holds low
// [R24] Eight pins carry minimum-mode counterparts
// [R25] After fourth state idle unless restarted
// [R26] Wait held while ready low
module cpu_bus_cycle_monitor (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  cyc_i,
  input  wire logic                  stb_i,
  input  wire logic                  we_i,
  input  wire logic [3:0]            adr_i,
  input  wire logic [3:0]            sel_i,
  input  wire logic [31:0]           dat_i,
  output logic      [31:0]           dat_o,
  output logic                       ack_o,
  input  wire monitor_pkg::cpu_max_t cpu_i,
  input  wire logic [15:0]           ad_i,
  input  wire logic [3:0]            addr_high_i,
  input  wire logic                  upper_byte_enable_n_i,
  input  wire logic                  buffered_ready_i,
  input  wire logic                  min_mode_i,
  input  wire logic                  maskable_irq_i,
  input  wire logic                  nonmaskable_irq_i,
  input  wire logic                  bank_enable_strap_i,
  input  wire logic                  select_polarity_strap_i,
  output logic      [7:0]            target_pins_o,
  output logic      [7:0]            target_pins_oe_o,
  output logic      [19:0]           la_addr_o,
  output logic      [15:0]           la_data_o,
  output monitor_pkg::la_ctrl_t      la_ctrl_o,
  output logic                       la_strobe_o
);

  typedef struct packed {
    monitor_pkg::bus_state_t state;
    logic [2:0]              prev_status;
    logic [2:0]              cyc_status;
    logic                    ale;
    logic                    mode_min;
    logic                    bank_en;
    logic                    io_m_pol;
    logic                    straps_loaded;
    logic [1:0]              ctrl;
    logic [1:0]              irq;
    logic [1:0]              irq_prev;
    logic [15:0]             cycles;
    logic                    ack;
    logic [31:0]             dat;
    logic [7:0]              pins;
    logic [7:0]              pins_oe;
    logic [19:0]             la_addr;
    logic [15:0]             la_data;
    monitor_pkg::la_ctrl_t   la_ctrl;
    logic                    la_strobe;
    logic [1:0]              fill;
  } mon_state_t;

  mon_state_t            s_q;
  mon_state_t            s_d;
  logic [20:0]           latched;
  logic [3:0]            q_level;
  logic                  q_last_first;
  logic                  q_second_first;
  logic                  start;
  logic                  is_write;
  logic                  is_mem;
  logic                  active;
  logic                  upper_en;
  logic [15:0]           lane_data;
  logic [1:0]            irq_rise;
  monitor_pkg::min_ctrl_t emu;

  // ==========================================================
  // Address latch and queue follower
  addr_latch u_latch (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .strobe_i  (s_q.ale),
    .bus_i     ({upper_byte_enable_n_i, addr_high_i, ad_i}),
    .latched_o (latched)
  );

  queue_follower u_queue (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .queue_status_i      (cpu_i.queue_status),
    .fill_bytes_i        (s_q.fill),
    .flush_exec_i        (s_q.ctrl[`CTRL_FLUSH_EXEC]),
    .level_o             (q_level),
    .last_first_o        (q_last_first),
    .second_last_first_o (q_second_first)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Straps are caught once, on the first clock after reset release
    if (!s_q.straps_loaded) begin
      s_d.straps_loaded = 1'b1;
      s_d.bank_en       = bank_enable_strap_i;      // see R12
      s_d.io_m_pol      = select_polarity_strap_i;  // see R14
    end
    s_d.mode_min    = min_mode_i;                   // see R15
    s_d.prev_status = cpu_i.cpu_status_n;
    start = (s_q.prev_status == `CODE_PASSIVE) && (cpu_i.cpu_status_n != `CODE_PASSIVE);  // see R4
    s_d.ale  = 1'b0;
    s_d.fill = 2'h0;

    // Cycle tracker
    unique case (s_q.state)
      monitor_pkg::idle_state: begin
        if (start) begin                            // see R3
          s_d.state = monitor_pkg::t1_state;        // see R5
        end
      end
      monitor_pkg::t1_state: s_d.state = monitor_pkg::t2_state;  // see R1
      monitor_pkg::t2_state: s_d.state = monitor_pkg::t3_state;
      monitor_pkg::t3_state, monitor_pkg::wait_state: begin
        s_d.state = buffered_ready_i ? monitor_pkg::t4_state : monitor_pkg::wait_state;  // see R2 see R26
      end
      monitor_pkg::t4_state: begin
        s_d.state = start ? monitor_pkg::t1_state : monitor_pkg::idle_state;  // see R25
        if (s_q.cyc_status == `CODE_CODE) begin
          s_d.fill = (s_q.bank_en && !s_q.la_addr[0]) ? 2'h2 : 2'h1;
        end
      end
      default: s_d.state = monitor_pkg::idle_state;
    endcase
    if (start && (s_q.state == monitor_pkg::idle_state || s_q.state == monitor_pkg::t4_state)) begin
      s_d.ale        = 1'b1;                        // see R4
      s_d.cyc_status = cpu_i.cpu_status_n;
      s_d.cycles     = s_q.cycles + 16'h0001;
    end

    // Cycle decode for the emulated controls
    is_write = (s_d.cyc_status == `CODE_IO_WR) || (s_d.cyc_status == `CODE_MEM_WR);
    is_mem   = s_d.cyc_status[2];
    active   = (s_d.state == monitor_pkg::t2_state) || (s_d.state == monitor_pkg::t3_state) ||
               (s_d.state == monitor_pkg::wait_state) || (s_d.state == monitor_pkg::t4_state);
    emu.mem_io                = s_d.io_m_pol ? !is_mem : is_mem;  // see R13 see R14
    emu.transfer_direction    = is_write;
    emu.data_enable_n         = !active;
    emu.interrupt_ack_cycle_n = !(active && s_d.cyc_status == `CODE_INTERRUPT_ACK_CYCLE);  // see R22
    emu.ale                   = s_d.ale;
    emu.write_n               = !(active && is_write);
    emu.hold_request          = !cpu_i.rq_gt0_n;
    emu.hold_acknowledge      = !cpu_i.rq_gt1_n;

    // Target pins: emulated in minimum mode, forwarded in maximum mode
    if (s_d.mode_min) begin
      s_d.pins    = emu;                            // see R16 see R24
      s_d.pins_oe = emu.hold_acknowledge ? 8'h07 : 8'hFF;
    end else begin
      s_d.pins    = {cpu_i.cpu_status_n, cpu_i.queue_status[0], cpu_i.queue_status[1],
                     cpu_i.lock_n, cpu_i.rq_gt0_n, cpu_i.rq_gt1_n};  // see R17
      s_d.pins_oe = (!cpu_i.rq_gt0_n || !cpu_i.rq_gt1_n) ? 8'h0F : 8'hFF;
    end

    // Analyzer feed: address held from the first state, data lanes per bank
    upper_en  = s_q.bank_en && !latched[20];        // see R11 see R12
    lane_data = ad_i;
    if (!upper_en) begin
      lane_data[15:8] = 8'h00;                      // see R9 see R10
    end
    if (s_q.bank_en && latched[0] && !latched[20]) begin
      lane_data[7:0] = 8'h00;                       // see R10
    end
    s_d.la_addr = latched[19:0];                    // see R6 see R23
    s_d.la_data = lane_data;                        // see R7 see R8
    s_d.la_ctrl.rd_wr                  = !is_write;
    s_d.la_ctrl.mem_io                 = s_d.mode_min ? emu.mem_io : is_mem;
    s_d.la_ctrl.code_fetch             = (s_d.cyc_status == `CODE_CODE);
    s_d.la_ctrl.irq                    = maskable_irq_i || nonmaskable_irq_i;
    s_d.la_ctrl.min_mode               = s_d.mode_min;
    s_d.la_ctrl.hold_ack               = emu.hold_acknowledge;
    s_d.la_ctrl.in_t1                  = (s_d.state == monitor_pkg::t1_state);
    s_d.la_ctrl.in_wait                = (s_d.state == monitor_pkg::wait_state);
    s_d.la_ctrl.last_byte_first_flag   = q_last_first;   // see R18
    s_d.la_ctrl.second_last_first_flag = q_second_first;
    // One sample per completed cycle; it follows the bus, not execution
    s_d.la_strobe = s_q.ctrl[`CTRL_LA_EN] && (s_q.state == monitor_pkg::t4_state);  // see R20

    // Interrupt request capture, edge set wins over a software clear
    irq_rise     = {nonmaskable_irq_i, maskable_irq_i} & ~s_q.irq_prev;
    s_d.irq_prev = {nonmaskable_irq_i, maskable_irq_i};
    if (s_q.ack && we_i && adr_i == `OFF_IRQ && sel_i[0]) begin
      s_d.irq = s_q.irq & ~dat_i[1:0];
    end
    s_d.irq = s_d.irq | irq_rise;                   // see R21

    // Wishbone slave: answer one cycle after the request, commit on the ack edge
    s_d.ack = cyc_i && stb_i && !s_q.ack;
    if (s_q.ack && we_i && adr_i == `OFF_CTRL && sel_i[0]) begin
      s_d.ctrl = dat_i[1:0];
    end
    s_d.dat = 32'h00000000;
    unique case (adr_i)
      `OFF_CTRL:   s_d.dat[1:0] = s_q.ctrl;
      `OFF_STATUS: begin
        s_d.dat[`STAT_STATE_LSB +: 3] = s_q.state;
        s_d.dat[`STAT_MODE_MIN]       = s_q.mode_min;
        s_d.dat[`STAT_BANK_EN]        = s_q.bank_en;
        s_d.dat[`STAT_IO_M_POL]       = s_q.io_m_pol;
        s_d.dat[`STAT_LEVEL_LSB +: 4] = q_level;
        s_d.dat[`STAT_LAST_F]         = q_last_first;
        s_d.dat[`STAT_SECOND_F]       = q_second_first;
      end
      `OFF_IRQ:    s_d.dat[1:0] = s_q.irq;
      `OFF_CYCLES: s_d.dat[15:0] = s_q.cycles;
      default:     s_d.dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q             <= '0;
      s_q.state       <= monitor_pkg::idle_state;
      s_q.prev_status <= `CODE_PASSIVE;
      s_q.cyc_status  <= `CODE_PASSIVE;
      s_q.ctrl        <= `CTRL_RESET;
      s_q.irq         <= `IRQ_RESET;
      s_q.pins        <= 8'hFF;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign dat_o            = s_q.dat;
  assign ack_o            = s_q.ack;
  assign target_pins_o    = s_q.pins;
  assign target_pins_oe_o = s_q.pins_oe;
  assign la_addr_o        = s_q.la_addr;
  assign la_data_o        = s_q.la_data;
  assign la_ctrl_o        = s_q.la_ctrl;
  assign la_strobe_o      = s_q.la_strobe;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence cycle_body_s;
    s_q.state == monitor_pkg::t2_state ##1 s_q.state == monitor_pkg::t3_state;
  endsequence

  sequence cycle_open_s;
    s_q.state == monitor_pkg::t1_state && s_q.ale;
  endsequence

  strobe_starts_t1_a: assert property (  // see R5
    (start && (s_q.state == monitor_pkg::idle_state || s_q.state == monitor_pkg::t4_state))
      |=> cycle_open_s)
    else $error("status change did not open a cycle");

  four_states_a: assert property (  // see R1
    cycle_open_s |=> cycle_body_s ##1 (s_q.state == monitor_pkg::t4_state ||
                                        s_q.state == monitor_pkg::wait_state))
    else $error("cycle skipped a state");

  wait_hold_a: assert property (  // see R26
    (s_q.state == monitor_pkg::t3_state || s_q.state == monitor_pkg::wait_state) && !buffered_ready_i
      |=> s_q.state == monitor_pkg::wait_state)
    else $error("wait not held while not ready");

  wait_exit_a: assert property (  // see R2
    s_q.state == monitor_pkg::wait_state && buffered_ready_i |=> s_q.state == monitor_pkg::t4_state)
    else $error("wait did not end on ready");

  idle_return_a: assert property (  // see R25
    s_q.state == monitor_pkg::t4_state && !start |=> s_q.state == monitor_pkg::idle_state [*1])
    else $error("no return to idle after last state");

  idle_stays_a: assert property (  // see R3
    s_q.state == monitor_pkg::idle_state && !start |=> s_q.state == monitor_pkg::idle_state)
    else $error("tracker left idle without bus activity");

  latch_hold_a: assert property (  // see R23
    !s_q.ale ##1 !s_q.ale |-> latched == $past(latched))
    else $error("address latch moved while strobe low");

  upper_lane_a: assert property (  // see R12
    !s_q.bank_en && s_q.straps_loaded |=> la_data_o[15:8] == 8'h00)
    else $error("upper data lane active on narrow variant");

  select_polarity_a: assert property (  // see R14
    s_q.mode_min && s_q.state == monitor_pkg::t2_state
      |-> target_pins_o[7] == (s_q.io_m_pol ^ s_q.cyc_status[2]))
    else $error("memory or io select has wrong polarity");

  irq_capture_a: assert property (  // see R21
    $rose(maskable_irq_i) |=> ##1 s_q.irq[`IRQ_MASKABLE])
    else $error("maskable request not captured");

endmodule : cpu_bus_cycle_monitor

// File: bench/cpu_bus_model.sv
// Processor model that runs one bus cycle at a time on the monitored bus
`timescale 1ns/10ps
module cpu_bus_model (
  input  wire logic        clk_i,
  output logic      [2:0]  status_n_o,
  output logic      [15:0] ad_o,
  output logic      [3:0]  addr_high_o,
  output logic             upper_byte_enable_n_o,
  output logic             buffered_ready_o
);
  initial begin
    status_n_o = 3'h7;
    ad_o = 16'h0000;
    addr_high_o = 4'h0;
    upper_byte_enable_n_o = 1'b1;
    buffered_ready_o = 1'b1;
  end
  // ==========================================================
  // One bus cycle with a given number of wait states
  task automatic run(input logic [2:0] code, input logic [19:0] addr, input logic [15:0] data, input logic wr,
                     input int waits);
    @(posedge clk_i);
    status_n_o <= code;
    ad_o <= addr[15:0];
    addr_high_o <= addr[19:16];
    upper_byte_enable_n_o <= 1'b0;
    buffered_ready_o <= (waits == 0);
    repeat (2) @(posedge clk_i);
    status_n_o <= 3'h7;
    // A floating bus is shown as the inverted address, never as the old value
    ad_o <= wr ? data : ~addr[15:0];
    repeat (1 + waits) @(posedge clk_i);
    buffered_ready_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    ad_o <= ~ad_o;
    upper_byte_enable_n_o <= 1'b1;
  endtask : run
endmodule : cpu_bus_model

// File: bench/tb_cpu_bus_cycle_monitor.sv
// Self-checking bench for the bus cycle monitor
`timescale 1ns/10ps
module tb_cpu_bus_cycle_monitor;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, bank = 1'b1, min = 1'b1, irq = 1'b0, nmi = 1'b0, pol = 1'b0, mio, la_strobe;
  logic [1:0] qs = 2'h0;
  logic rq0 = 1'b1, rq1 = 1'b1, ube, rdy;
  logic [2:0] st;
  logic [15:0] ad, la_data;
  logic [3:0] ah;
  logic [7:0] pins, oe;
  logic [19:0] la_addr;
  monitor_pkg::la_ctrl_t la_ctrl;
  monitor_pkg::cpu_max_t cpu_bus;
  int error_cnt = 0, n_tests = 0, n_t1, n_w, n_st, n_ale;

  assign cpu_bus = {st, qs, 1'b1, rq0, rq1};
  always #12.5 clk = ~clk;

  cpu_bus_model cpu (.clk_i(clk), .status_n_o(st), .ad_o(ad), .addr_high_o(ah),
    .upper_byte_enable_n_o(ube), .buffered_ready_o(rdy));

  cpu_bus_cycle_monitor dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .cpu_i(cpu_bus), .ad_i(ad), .addr_high_i(ah),
    .upper_byte_enable_n_i(ube), .buffered_ready_i(rdy), .min_mode_i(min), .maskable_irq_i(irq),
    .nonmaskable_irq_i(nmi), .bank_enable_strap_i(bank), .select_polarity_strap_i(pol),
    .target_pins_o(pins), .target_pins_oe_o(oe), .la_addr_o(la_addr), .la_data_o(la_data),
    .la_ctrl_o(la_ctrl), .la_strobe_o(la_strobe));

  // ==========================================================
  // Observers of the analyzer feed and the emulated pins
  always @(posedge clk) begin
    if (la_ctrl.in_t1 === 1'b1) n_t1++;
    if (la_ctrl.in_wait === 1'b1) n_w++;
    if (la_strobe === 1'b1) n_st++;
    if (min && pins[3] === 1'b1) begin
      n_ale++;
      mio = pins[7];
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // Register bus; only the watchdog ends a wait on a dead slave
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic do_reset(input logic p, input logic b);
    pol <= p;
    bank <= b;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  // ==========================================================
  // Scenarios
  task automatic bus_cycle(input logic [2:0] code, input logic [19:0] a, input int w, input logic exp_mio,
                           input int exp_st);
    logic wr;
    logic [15:0] exp_d;
    wr = (code == 3'h2 || code == 3'h6);
    // Lanes seen after the cycle: read shows the address again, write the inverted data
    exp_d = wr ? 16'h5A3C : a[15:0];
    if (!bank) exp_d[15:8] = 8'h00;
    if (bank && a[0]) exp_d[7:0] = 8'h00;
    n_t1 = 0; n_w = 0; n_st = 0; n_ale = 0;
    cpu.run(code, a, 16'hA5C3, wr, w);
    repeat (3) @(posedge clk);
    chk(n_t1, 1);
    chk(n_ale, 1);
    chk(n_w, w);
    chk(n_st, exp_st);
    chk(la_addr, a);
    chk(mio, exp_mio);
    chk(la_data, exp_d);
    chk({la_ctrl.rd_wr, la_ctrl.code_fetch}, {!wr, code == 3'h4});
  endtask : bus_cycle

  task automatic queue_flags;
    wb(0, 4'h4, 0); chk(q, 32'h98);
    qs <= 2'h1;
    @(posedge clk) qs <= 2'h3;
    @(posedge clk) qs <= 2'h0;
    repeat (2) @(posedge clk);
    wb(0, 4'h4, 0); chk(q, 32'h818);
    qs <= 2'h1;
    @(posedge clk) qs <= 2'h2;
    @(posedge clk) qs <= 2'h0;
    repeat (2) @(posedge clk);
    wb(0, 4'h4, 0); chk(q, 32'h18);
  endtask : queue_flags

  task automatic irq_capture;
    irq <= 1'b1;
    repeat (3) @(posedge clk);
    wb(0, 4'h8, 0); chk(q, 32'h1);
    nmi <= 1'b1; irq <= 1'b0;
    repeat (3) @(posedge clk);
    nmi <= 1'b0;
    wb(0, 4'h8, 0); chk(q, 32'h3);
    wb(1, 4'h8, 32'h3);
    wb(0, 4'h8, 0); chk(q, 32'h0);
    bus_cycle(3'h0, 20'h00000, 0, 1'b0, 1);
    bus_cycle(3'h0, 20'h00000, 0, 1'b0, 1);
  endtask : irq_capture

  task automatic modes;
    rq1 <= 1'b0;
    repeat (3) @(posedge clk);
    chk(oe, 8'h07);
    chk(pins[0], 1'b1);
    chk({la_ctrl.min_mode, la_ctrl.hold_ack}, 2'h3);
    min <= 1'b0; rq1 <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pins, 8'hE7);
    chk(la_ctrl.min_mode, 1'b0);
    chk(oe, 8'hFF);
    rq0 <= 1'b0;
    repeat (3) @(posedge clk);
    chk(oe, 8'h0F);
  endtask : modes

  initial begin
    #(25 * 5000);
    error_cnt++;
    stop_test();
  end

  initial begin
    do_reset(1'b0, 1'b1);
    wb(0, 4'h0, 0); chk(q, 32'h1);
    wb(0, 4'h8, 0); chk(q, 32'h0);
    wb(0, 4'h2, 0); chk(q, 32'h0);
    wb(0, 4'h4, 0); chk(q, 32'h18);
    bus_cycle(3'h4, 20'h12340, 0, 1'b1, 1);
    queue_flags();
    bus_cycle(3'h2, 20'h000F0, 2, 1'b0, 1);
    irq_capture();
    wb(1, 4'h0, 32'h0);
    bus_cycle(3'h6, 20'hABCDF, 1, 1'b1, 0);
    do_reset(1'b1, 1'b0);
    wb(0, 4'h4, 0); chk(q, 32'h28);
    bus_cycle(3'h5, 20'h54321, 0, 1'b0, 1);
    modes();
    stop_test();
  end
endmodule : tb_cpu_bus_cycle_monitor
